// ---- shared/zsd_consts.svh ----
// Timing and code constants of the zero-speed diagnostic block
`ifndef ZSD_CONSTS_SVH
`define ZSD_CONSTS_SVH
`define ZSD_CLK_HZ          200000000
`define ZSD_BLINK_MS        250
`define ZSD_BLINK_CYC       ((`ZSD_CLK_HZ / 1000) * `ZSD_BLINK_MS)
`define ZSD_PAUSE_SLOTS     4
`define ZSD_DIFF_MS         10000
`define ZSD_DIFF_CYC        ((`ZSD_CLK_HZ / 1000) * `ZSD_DIFF_MS)
`define ZSD_DELAY_MIN_MS    500
`define ZSD_DELAY_MAX_MS    20000
`define ZSD_DELAY_MS_W      15
`define ZSD_LAMP_OFF        2'h0
`define ZSD_LAMP_GREEN      2'h1
`define ZSD_LAMP_RED        2'h2
`define ZSD_LAMP_ORANGE     2'h3
`define ZSD_CODE_INT_A      3'h1
`define ZSD_CODE_SUPPLY     3'h2
`define ZSD_CODE_INT_B      3'h3
`define ZSD_CODE_SIMUL      3'h4
`define ZSD_CODE_INT_C      3'h5
`endif

// ---- shared/zsd_pkg.sv ----
// Types of the zero-speed diagnostic block
`default_nettype none
package zsd_pkg;
    typedef enum logic [2:0] {
        ZSD_SELFTEST,
        ZSD_STANDSTILL,
        ZSD_MOVEMENT,
        ZSD_RUNDOWN,
        ZSD_INT_ERR,
        ZSD_EXT_ERR,
        ZSD_OPEN_LINE
    } zsd_state_t;
    typedef logic [1:0] zsd_lamp_t;
endpackage
`default_nettype wire

// ---- testbench/test_zero_speed_diagnostic_status.sv ----
// Self-checking bench for the zero-speed diagnostic block
`default_nettype none
`include "zsd_consts.svh"
module test_zero_speed_diagnostic_status import zsd_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    localparam zsd_lamp_t LO = `ZSD_LAMP_OFF;
    localparam zsd_lamp_t LG = `ZSD_LAMP_GREEN;
    localparam zsd_lamp_t LR = `ZSD_LAMP_RED;
    localparam zsd_lamp_t LY = `ZSD_LAMP_ORANGE;
    localparam int SLOT = 4;
    logic clk_i, rst_b_i, st_done, st_fail, ma, mb, lopen, dc, sbad, ierr;
    logic [1:0] kind, view;
    logic [14:0] dly;
    zsd_lamp_t pwr, stl;
    logic pl, ph, mo, fo, en;
    zsd_state_t state;
    int fails = 0;
    int checks = 0;

    zsd_diag #(.DIFF_CYC(100), .SLOT_CYC(SLOT), .MS_CYC(2)) u_dut (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .selftest_done_i(st_done), .selftest_fail_i(st_fail),
        .motion_a_i(ma), .motion_b_i(mb), .line_open_i(lopen), .dc_detect_i(dc),
        .supply_bad_i(sbad), .int_err_kind_i(kind), .int_err_i(ierr), .delay_ms_i(dly),
        .power_state_lamp_o(pwr), .standstill_lamp_o(stl), .param_lamp_low_o(pl),
        .param_lamp_high_o(ph), .motion_status_output_o(mo), .fault_status_output_o(fo),
        .enable_path_o(en), .state_o(state));
    zsd_ctrl_model u_ctrl (.clk_i(clk_i), .rst_b_i(rst_b_i), .motion_status_i(mo),
        .fault_status_i(fo), .view_o(view));

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic end_of_test();
        if (fails == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic wait_en(input logic v, input int lim);
        int n = 0;
        while (en !== v && n < lim) begin
            @(negedge clk_i);
            n++;
        end
        if (en !== v) begin
            chk("enable wait", en, v);
            end_of_test();
        end
    endtask
    task automatic outs(input zsd_lamp_t s, input logic m, f, e, input string w);
        chk({w, " stop lamp"}, stl, s);
        chk({w, " param lamps"}, {pl, ph}, 2'h0);
        chk({w, " status"}, {mo, fo}, {m, f});
        chk({w, " enable"}, en, e);
    endtask
    // Rising edges over exactly one frame give the pulse count at any phase
    task automatic blink_code(input int code, input string w);
        int n = 0;
        logic prev;
        prev = (pwr === LR);
        repeat ((2 * code + 4) * SLOT) begin
            @(negedge clk_i);
            if ((pwr === LR) && !prev) n++;
            prev = (pwr === LR);
        end
        chk(w, n, code);
    endtask
    task automatic do_reset();
        rst_b_i = 1'b0;
        cyc(6);
        rst_b_i = 1'b1;
        wait_en(1'b1, 50);
        chk("power lamp", pwr, LG);
        outs(LG, 1'b1, 1'b1, 1'b1, "ready");
        chk("state", state, ZSD_STANDSTILL);
    endtask
    task automatic t_run(input logic [14:0] ms, input int exp);
        int n = 0;
        bit on_seen = 0;
        bit off_seen = 0;
        dly = ms;
        ma = 1'b1;
        mb = 1'b1;
        wait_en(1'b0, 10);
        cyc(2);
        chk("moving power lamp", pwr, LG);
        outs(LO, 1'b0, 1'b1, 1'b0, "moving");
        chk("ctrl moving", view, 2'h1);
        ma = 1'b0;
        mb = 1'b0;
        while (en !== 1'b1 && n < exp + 40) begin
            @(negedge clk_i);
            n++;
            on_seen |= (n > 8 && en !== 1'b1 && stl === LG);
            off_seen |= (n > 8 && en !== 1'b1 && stl === LO);
        end
        chk("rundown flash", {on_seen, off_seen}, 2'h3);
        chk("delay window", n >= exp && n <= exp + 12, 1'b1);
        if (en !== 1'b1) end_of_test();
        outs(LG, 1'b1, 1'b1, 1'b1, "settled");
        cyc(1);
        chk("ctrl standstill", view, 2'h2);
    endtask
    task automatic t_supply();
        sbad = 1'b1;
        cyc(12);
        outs(LO, 1'b0, 1'b0, 1'b0, "supply");
        blink_code(2, "supply code");
        chk("ctrl fault", view, 2'h0);
        sbad = 1'b0;
        wait_en(1'b1, 1100);
    endtask
    task automatic t_simul();
        ma = 1'b1;
        cyc(12);
        outs(LO, 1'b0, 1'b0, 1'b0, "one channel");
        blink_code(4, "one channel code");
        cyc(60);
        chk("slow rundown fault line", fo, 1'b1);
        blink_code(4, "slow rundown code");
        ma = 1'b0;
        wait_en(1'b1, 1100);
    endtask
    task automatic t_open();
        lopen = 1'b1;
        cyc(12);
        chk("open power lamp", pwr, LY);
        outs(LO, 1'b0, 1'b0, 1'b0, "open lines");
        lopen = 1'b0;
        dc = 1'b1;
        cyc(12);
        chk("dc power lamp", pwr, LY);
        chk("dc fault line", fo, 1'b1);
        dc = 1'b0;
        wait_en(1'b1, 1100);
    endtask
    task automatic t_internal();
        for (int k = 0; k < 3; k++) begin
            kind = k[1:0];
            ierr = 1'b1;
            cyc(12);
            outs(LO, 1'b0, 1'b0, 1'b0, "internal");
            ierr = 1'b0;
            cyc(4);
            blink_code(2 * k + 1, "internal code");
            chk("internal held", state, ZSD_INT_ERR);
            do_reset();
        end
    endtask

    initial begin
        {rst_b_i, st_fail, ma, mb, lopen, dc, sbad, ierr, kind} = '0;
        st_done = 1'b1;
        dly = 15'h64;
        do_reset();
        t_run(15'h64, 1000);
        t_supply();
        t_simul();
        t_open();
        t_run(15'h7530, 40000);
        t_internal();
        end_of_test();
    end
endmodule
`default_nettype wire

// ---- testbench/zsd_ctrl_model.sv ----
// Higher-level controller that reads the two status outputs
`default_nettype none
module zsd_ctrl_model (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    // Status lines from the device
    input  wire logic       motion_status_i,
    input  wire logic       fault_status_i,
    // 0 not ok, 1 ok moving, 2 ok standstill, 3 impossible pair
    output logic [1:0]      view_o
);
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            view_o <= 2'h0;
        end else begin
            view_o <= !fault_status_i ? {1'b0, motion_status_i} + {motion_status_i, 1'b0}
                    : (motion_status_i ? 2'h2 : 2'h1);
        end
    end
endmodule
`default_nettype wire

// ---- testbench/zsd_diag_properties.sv ----
// Port-level checks for the zero-speed diagnostic block
`default_nettype none
`include "zsd_consts.svh"
module zsd_diag_properties
    import zsd_pkg::*;
#(
    parameter int MS_CYC = 200000
) (
    // Clock and reset
    input wire logic                clk_i,
    input wire logic                rst_b_i,
    // Watched inputs
    input wire logic                motion_a_i,
    input wire logic                motion_b_i,
    input wire logic                supply_bad_i,
    // Watched outputs
    input wire zsd_pkg::zsd_lamp_t  power_state_lamp_o,
    input wire zsd_pkg::zsd_lamp_t  standstill_lamp_o,
    input wire logic                param_lamp_low_o,
    input wire logic                param_lamp_high_o,
    input wire logic                motion_status_output_o,
    input wire logic                fault_status_output_o,
    input wire logic                enable_path_o,
    input wire zsd_pkg::zsd_state_t state_o
);
    import zsd_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    // Counts quiet cycles since either channel last saw motion
    logic [31:0] quiet_cnt_reg;
    logic        seen_motion_reg;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            quiet_cnt_reg <= 32'h0;
        end else if (motion_a_i || motion_b_i) begin
            quiet_cnt_reg <= 32'h0;
        end else if (quiet_cnt_reg != 32'hffffffff) begin
            quiet_cnt_reg <= quiet_cnt_reg + 32'h1;
        end
    end
    // The first close after power-up needs no delay, so only later closes are timed
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            seen_motion_reg <= 1'b0;
        end else if (motion_a_i || motion_b_i) begin
            seen_motion_reg <= 1'b1;
        end
    end

    sequence s_both_moving;
        (motion_a_i && motion_b_i) [*6];
    endsequence
    sequence s_supply_bad;
        supply_bad_i [*6];
    endsequence

    a_closed_means_ready: assert property (enable_path_o |->
        power_state_lamp_o == `ZSD_LAMP_GREEN && standstill_lamp_o == `ZSD_LAMP_GREEN
        && motion_status_output_o && fault_status_output_o)
        else $error("enable closed outside healthy standstill");
    a_param_lamps_dark: assert property (!param_lamp_low_o && !param_lamp_high_o)
        else $error("parameter lamp lit");
    a_red_others_off: assert property (power_state_lamp_o == `ZSD_LAMP_RED |->
        standstill_lamp_o == `ZSD_LAMP_OFF && !enable_path_o)
        else $error("red power lamp with other lamp or closed path");
    a_orange_others_off: assert property (power_state_lamp_o == `ZSD_LAMP_ORANGE |->
        standstill_lamp_o == `ZSD_LAMP_OFF && !enable_path_o)
        else $error("orange power lamp with other lamp or closed path");
    a_internal_error_latch: assert property (state_o == ZSD_INT_ERR |=>
        state_o == ZSD_INT_ERR)
        else $error("internal error left without reset");
    a_motion_opens_path: assert property (s_both_moving |-> !enable_path_o)
        else $error("path closed during motion");
    a_supply_opens_path: assert property (s_supply_bad |-> !enable_path_o)
        else $error("path closed with bad supply");
    a_delay_before_close: assert property ($rose(enable_path_o) && seen_motion_reg |->
        quiet_cnt_reg >= `ZSD_DELAY_MIN_MS * MS_CYC)
        else $error("path closed before minimum delay");
    a_fault_drops_motion: assert property (!fault_status_output_o |->
        !motion_status_output_o)
        else $error("motion output high while not healthy");
endmodule
bind zsd_diag zsd_diag_properties #(.MS_CYC(MS_CYC)) u_props (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .motion_a_i(motion_a_i), .motion_b_i(motion_b_i),
    .supply_bad_i(supply_bad_i), .power_state_lamp_o(power_state_lamp_o),
    .standstill_lamp_o(standstill_lamp_o), .param_lamp_low_o(param_lamp_low_o),
    .param_lamp_high_o(param_lamp_high_o), .motion_status_output_o(motion_status_output_o),
    .fault_status_output_o(fault_status_output_o), .enable_path_o(enable_path_o),
    .state_o(state_o));
`default_nettype wire

// ---- verilog/zsd_blinker.sv ----
// Repeating blink-code generator for the power lamp
`default_nettype none
`include "zsd_consts.svh"
module zsd_blinker #(
    parameter int SLOT_CYC = `ZSD_BLINK_CYC
) (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    // Code request, zero means idle
    input  wire logic [2:0] code_i,
    // Lamp phase
    output logic            lit_o
);
    if (SLOT_CYC < 1) begin : g_bad_slot
        $error("zsd_blinker: SLOT_CYC must be at least 1");
    end

    logic [31:0] slot_cnt_reg;
    logic [3:0]  slot_reg;
    logic [2:0]  code_reg;
    logic        tick;
    logic [3:0]  frame_len;

    assign tick      = (slot_cnt_reg == 32'(SLOT_CYC - 1));
    // Each pulse is one slot on, one slot off, then a pause closes the frame
    assign frame_len = 4'({code_reg, 1'b0}) + 4'(`ZSD_PAUSE_SLOTS);

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            slot_cnt_reg <= 32'h0;
        end else if (tick || code_i != code_reg) begin
            slot_cnt_reg <= 32'h0;
        end else begin
            slot_cnt_reg <= slot_cnt_reg + 32'h1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            code_reg <= 3'h0;
            slot_reg <= 4'h0;
        end else if (code_i != code_reg) begin
            // Restart the frame so a new code is never shown half-way
            code_reg <= code_i;
            slot_reg <= 4'h0;
        end else if (tick) begin
            slot_reg <= (slot_reg == frame_len - 4'h1) ? 4'h0 : slot_reg + 4'h1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lit_o <= 1'b0;
        end else begin
            lit_o <= (code_reg != 3'h0) && !slot_reg[0]
                     && (slot_reg < 4'({code_reg, 1'b0}));
        end
    end
endmodule
`default_nettype wire

// ---- verilog/zsd_diag.sv ----
// Zero-speed monitor diagnostics: state, lamps, status outputs, enable path
// How it works
// (RULE_01) Clean self-test or finished delay gives standstill: green lamps, path closed.
// (RULE_02) Motion: power lamp green, others off, enabling path open.
// (RULE_03) Below threshold the delay runs; standstill lamp flashes, path stays open.
// (RULE_04) Motor start drops all outputs; they return after standstill plus delay. Here the power lamp stays green and fault status stays high.
// (RULE_05) Status: both high at healthy standstill, motion low when moving, both low on fault.
// (RULE_06) Blinking error states: power lamp flashes red, other lamps off.
// (RULE_07) Internal errors blink codes 1, 3, 5 and latch until power cycle.
// (RULE_08) Supply out of range is an external error, blink code 2.
// (RULE_09) Single-channel signal is an external error, blink code 4.
// (RULE_10) Channel difference over 10 s from run-down blinks code 4, no fault.
// (RULE_11) Open measuring lines: steady orange power lamp, other lamps off.
// (RULE_12) DC motor shows the same orange; clears itself after DC shutdown.
// (RULE_13) Switch-on delay is selectable from 0.5 s up to 20 s.
// (RULE_14) Any true error keeps the enabling path open.
// (RULE_15) Blink codes repeat while the condition lasts.
`default_nettype none
`include "zsd_consts.svh"
module zsd_diag
    import zsd_pkg::*;
#(
    parameter int CLK_HZ   = `ZSD_CLK_HZ,
    parameter int DIFF_CYC = `ZSD_DIFF_CYC,
    parameter int SLOT_CYC = `ZSD_BLINK_CYC,
    parameter int MS_CYC   = CLK_HZ / 1000
) (
    // Clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       rst_b_i,
    // Measurement front end, asynchronous
    input  wire logic                       selftest_done_i,
    input  wire logic                       selftest_fail_i,
    input  wire logic                       motion_a_i,
    input  wire logic                       motion_b_i,
    input  wire logic                       line_open_i,
    input  wire logic                       dc_detect_i,
    input  wire logic                       supply_bad_i,
    input  wire logic [1:0]                 int_err_kind_i,
    input  wire logic                       int_err_i,
    // Switch-on delay setting in milliseconds
    input  wire logic [`ZSD_DELAY_MS_W-1:0] delay_ms_i,
    // Lamps
    output zsd_pkg::zsd_lamp_t              power_state_lamp_o,
    output zsd_pkg::zsd_lamp_t              standstill_lamp_o,
    output logic                            param_lamp_low_o,
    output logic                            param_lamp_high_o,
    // Status outputs and enabling path
    output logic                            motion_status_output_o,
    output logic                            fault_status_output_o,
    output logic                            enable_path_o,
    output zsd_pkg::zsd_state_t             state_o
);
    if (MS_CYC < 1 || DIFF_CYC < 1 || SLOT_CYC < 1 || CLK_HZ < 1) begin : g_bad_timing
        $error("zsd_diag: timing parameters must be positive");
    end

    localparam int NSYNC = 10;

    // Two-stage synchronisers for all front-end levels
    logic [NSYNC-1:0] async_in;
    logic [NSYNC-1:0] sync1_reg;
    logic [NSYNC-1:0] sync2_reg;
    assign async_in = {selftest_done_i, selftest_fail_i, motion_a_i, motion_b_i,
                       line_open_i, dc_detect_i, supply_bad_i, int_err_kind_i,
                       int_err_i};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    sync1_reg[gi] <= 1'b0;
                    sync2_reg[gi] <= 1'b0;
                end else begin
                    sync1_reg[gi] <= async_in[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                end
            end
        end
    endgenerate

    logic       st_done, st_fail, mov_a, mov_b, line_open, dc_det, supply_bad, int_err;
    logic [1:0] int_kind;
    assign {st_done, st_fail, mov_a, mov_b, line_open, dc_det, supply_bad, int_kind,
            int_err} = sync2_reg;

    logic motion_any;
    logic mismatch;
    assign motion_any = mov_a || mov_b;
    assign mismatch   = mov_a ^ mov_b;

    // Delay setting, clamped into the legal range
    logic [`ZSD_DELAY_MS_W-1:0] delay_ms;
    always_comb begin
        if (delay_ms_i < `ZSD_DELAY_MS_W'(`ZSD_DELAY_MIN_MS)) begin
            delay_ms = `ZSD_DELAY_MS_W'(`ZSD_DELAY_MIN_MS);   // [RULE_13]
        end else if (delay_ms_i > `ZSD_DELAY_MS_W'(`ZSD_DELAY_MAX_MS)) begin
            delay_ms = `ZSD_DELAY_MS_W'(`ZSD_DELAY_MAX_MS);   // [RULE_13]
        end else begin
            delay_ms = delay_ms_i;
        end
    end

    // Internal error latch: only a power-on reset clears it
    logic       int_latch_reg;
    logic       int_req_reg;
    logic [2:0] int_code_reg;
    // Kind bits are synchronised one by one, so they are read a cycle after the
    // request is first seen, once any skew between them has settled
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            int_req_reg <= 1'b0;
        end else begin
            int_req_reg <= int_err || st_fail;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            int_latch_reg <= 1'b0;
            int_code_reg  <= 3'h0;
        end else if (!int_latch_reg && int_req_reg && (int_err || st_fail)) begin
            int_latch_reg <= 1'b1;                            // [RULE_07]
            case (int_kind)
                2'h0:    int_code_reg <= `ZSD_CODE_INT_A;
                2'h1:    int_code_reg <= `ZSD_CODE_INT_B;
                default: int_code_reg <= `ZSD_CODE_INT_C;
            endcase
        end
    end

    // Channel difference timer; a long mismatch is run-down, not a fault
    logic [31:0] diff_cnt_reg;
    logic        diff_long_reg;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            diff_cnt_reg  <= 32'h0;
            diff_long_reg <= 1'b0;
        end else if (!mismatch) begin
            diff_cnt_reg  <= 32'h0;
            diff_long_reg <= 1'b0;
        end else if (diff_cnt_reg >= 32'(DIFF_CYC - 1)) begin
            diff_long_reg <= 1'b1;                            // [RULE_10]
        end else begin
            diff_cnt_reg <= diff_cnt_reg + 32'h1;
        end
    end

    // Millisecond prescaler and switch-on delay counter
    zsd_state_t                 state_reg;
    logic [31:0]                ms_pre_reg;
    logic [`ZSD_DELAY_MS_W-1:0] ms_cnt_reg;
    logic                       ms_tick;
    assign ms_tick = (ms_pre_reg == 32'(MS_CYC - 1));

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ms_pre_reg <= 32'h0;
            ms_cnt_reg <= '0;
        end else if (state_reg != ZSD_RUNDOWN) begin
            ms_pre_reg <= 32'h0;
            ms_cnt_reg <= '0;
        end else if (ms_tick) begin
            ms_pre_reg <= 32'h0;
            ms_cnt_reg <= ms_cnt_reg + 1'b1;
        end else begin
            ms_pre_reg <= ms_pre_reg + 32'h1;
        end
    end

    logic delay_done;
    assign delay_done = ms_tick && (ms_cnt_reg + 1'b1 >= delay_ms);

    // External blinking error: supply, or a short mismatch
    logic ext_err;
    assign ext_err = supply_bad || (mismatch && !diff_long_reg);

    // Operating state
    zsd_state_t state_next;
    always_comb begin
        state_next = state_reg;
        if (int_latch_reg) begin
            state_next = ZSD_INT_ERR;                          // [RULE_07]
        end else if (state_reg == ZSD_SELFTEST && !st_done) begin
            state_next = ZSD_SELFTEST;
        end else if (ext_err) begin
            state_next = ZSD_EXT_ERR;                          // [RULE_08] [RULE_09]
        end else if (line_open || dc_det) begin
            state_next = ZSD_OPEN_LINE;                        // [RULE_11] [RULE_12]
        end else begin
            case (state_reg)
                // A motor already turning at power-up must never see the path close
                ZSD_SELFTEST: begin
                    state_next = motion_any ? ZSD_MOVEMENT : ZSD_STANDSTILL; // [RULE_01]
                end
                ZSD_STANDSTILL: begin
                    if (motion_any)
                        state_next = ZSD_MOVEMENT;             // [RULE_04]
                end
                ZSD_MOVEMENT: begin
                    if (!motion_any)
                        state_next = ZSD_RUNDOWN;              // [RULE_03]
                end
                ZSD_RUNDOWN: begin
                    if (motion_any)
                        state_next = ZSD_MOVEMENT;
                    else if (delay_done)
                        state_next = ZSD_STANDSTILL;           // [RULE_01] [RULE_04]
                end
                // Leaving an external error or open lines passes through run-down so the delay is honoured
                ZSD_EXT_ERR,
                ZSD_OPEN_LINE: state_next = motion_any ? ZSD_MOVEMENT : ZSD_RUNDOWN;
                default:       state_next = ZSD_INT_ERR;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg <= ZSD_SELFTEST;
        end else begin
            state_reg <= state_next;
        end
    end

    // Blink code selection
    logic [2:0] blink_code;
    logic       blink_lit;
    logic       flash_lit;
    always_comb begin
        case (state_reg)
            ZSD_INT_ERR: blink_code = int_code_reg;
            ZSD_EXT_ERR: blink_code = supply_bad ? `ZSD_CODE_SUPPLY : `ZSD_CODE_SIMUL;
            default:     blink_code = (diff_long_reg && mismatch) ? `ZSD_CODE_SIMUL : 3'h0;
        endcase
    end

    zsd_blinker #(
        .SLOT_CYC (SLOT_CYC)
    ) u_blink (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .code_i  (blink_code),                                 // [RULE_15]
        .lit_o   (blink_lit)
    );

    // Plain one-pulse code gives the run-down flash of the standstill lamp
    zsd_blinker #(
        .SLOT_CYC (SLOT_CYC)
    ) u_flash (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .code_i  ((state_reg == ZSD_RUNDOWN) ? 3'h1 : 3'h0),
        .lit_o   (flash_lit)
    );

    // Registered outputs; any error keeps the path open
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            power_state_lamp_o     <= `ZSD_LAMP_OFF;
            standstill_lamp_o      <= `ZSD_LAMP_OFF;
            param_lamp_low_o       <= 1'b0;
            param_lamp_high_o      <= 1'b0;
            motion_status_output_o <= 1'b0;
            fault_status_output_o  <= 1'b0;
            enable_path_o          <= 1'b0;
        end else begin
            param_lamp_low_o  <= 1'b0;
            param_lamp_high_o <= 1'b0;
            enable_path_o     <= (state_reg == ZSD_STANDSTILL);           // [RULE_02] [RULE_14]
            case (state_reg)
                ZSD_STANDSTILL: begin
                    power_state_lamp_o     <= (blink_code != 3'h0)
                                              ? (blink_lit ? `ZSD_LAMP_RED : `ZSD_LAMP_OFF)
                                              : `ZSD_LAMP_GREEN;         // [RULE_01] [RULE_10]
                    standstill_lamp_o      <= `ZSD_LAMP_GREEN;            // [RULE_01]
                    motion_status_output_o <= 1'b1;                       // [RULE_05]
                    fault_status_output_o  <= 1'b1;                       // [RULE_05]
                end
                ZSD_MOVEMENT,
                ZSD_RUNDOWN: begin
                    power_state_lamp_o     <= (blink_code != 3'h0)
                                              ? (blink_lit ? `ZSD_LAMP_RED : `ZSD_LAMP_OFF)
                                              : `ZSD_LAMP_GREEN;         // [RULE_02] [RULE_10]
                    standstill_lamp_o      <= (state_reg == ZSD_RUNDOWN && flash_lit)
                                              ? `ZSD_LAMP_GREEN : `ZSD_LAMP_OFF; // [RULE_03]
                    motion_status_output_o <= 1'b0;                       // [RULE_05]
                    fault_status_output_o  <= 1'b1;                       // [RULE_05]
                end
                ZSD_INT_ERR,
                ZSD_EXT_ERR: begin
                    power_state_lamp_o     <= blink_lit ? `ZSD_LAMP_RED : `ZSD_LAMP_OFF; // [RULE_06]
                    standstill_lamp_o      <= `ZSD_LAMP_OFF;              // [RULE_06]
                    motion_status_output_o <= 1'b0;                       // [RULE_05]
                    fault_status_output_o  <= 1'b0;                       // [RULE_05]
                end
                ZSD_OPEN_LINE: begin
                    power_state_lamp_o     <= `ZSD_LAMP_ORANGE;           // [RULE_11] [RULE_12]
                    standstill_lamp_o      <= `ZSD_LAMP_OFF;
                    motion_status_output_o <= 1'b0;
                    // DC operation is not a fault; an open line is
                    fault_status_output_o  <= dc_det && !line_open;       // [RULE_12]
                end
                default: begin
                    power_state_lamp_o     <= `ZSD_LAMP_OFF;
                    standstill_lamp_o      <= `ZSD_LAMP_OFF;
                    motion_status_output_o <= 1'b0;
                    fault_status_output_o  <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_o <= ZSD_SELFTEST;
        end else begin
            state_o <= state_reg;
        end
    end
endmodule
`default_nettype wire
